// >>> sptms_channel_detect.v
// one slave controller's eight request detectors
// assumes request inputs already synchronised to clk_sys
`timescale 1ns/100ps
`include "sptms_consts.vh"
module sptms_channel_detect (
	input  wire       clk_sys,
	input  wire       reset_n,
	input  wire [7:0] mode_sel,
	input  wire [7:0] req_in,
	input  wire [7:0] req_ack,
	output reg  [7:0] req_pend_reg
);
	reg  [7:0] req_prev_reg;
	reg  [7:0] req_pend_next;
	integer    i;

	always @* begin
		req_pend_next = req_pend_reg;
		for (i = 0; i < 8; i = i + 1) begin
			if (mode_sel[i] == `SPTMS_MODE_LEVEL) begin
				req_pend_next[i] = req_in[i]; // see R9
			end else if (req_in[i] && !req_prev_reg[i]) begin
				req_pend_next[i] = 1'h1; // see R9
			end else if (req_ack[i]) begin
				req_pend_next[i] = 1'h0;
			end
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			req_prev_reg <= 8'h00;
			req_pend_reg <= 8'h00;
		end else begin
			req_prev_reg <= req_in;
			req_pend_reg <= req_pend_next;
		end
	end
endmodule

// >>> sptms_checker.sv
// port assertions for the trigger-mode select block
// assumes a bind onto sptms_top with ports matched by name
`timescale 1ns/100ps
module sptms_checker (
	input wire        clk_sys,
	input wire        reset_n,
	input wire [11:0] cfg_addr,
	input wire        cfg_rd,
	input wire        cfg_wr,
	input wire [7:0]  cfg_wdata,
	input wire [7:0]  cfg_rdata_reg,
	input wire        slave_one_global_override,
	input wire        slave_two_global_override,
	input wire        slave_one_global_level_select,
	input wire        slave_two_global_level_select,
	input wire [7:0]  slave_one_mode_reg,
	input wire [7:0]  slave_two_mode_reg,
	input wire [7:0]  slave_one_req_in,
	input wire [7:0]  slave_two_req_in,
	input wire [7:0]  slave_one_req_pend,
	input wire [7:0]  slave_two_req_pend
);
	wire       o1 = slave_one_global_override;
	wire       o2 = slave_two_global_override;
	wire [7:0] e1 = {8{slave_one_global_level_select}};
	wire [7:0] e2 = {8{slave_two_global_level_select}};
	wire [7:0] m1 = slave_one_mode_reg;
	wire [7:0] m2 = slave_two_mode_reg;
	wire [7:0] r1 = slave_one_req_in;
	wire [7:0] r2 = slave_two_req_in;
	wire [7:0] p1 = slave_one_req_pend;
	wire [7:0] p2 = slave_two_req_pend;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_wr(ad, ov);
		cfg_wr && cfg_addr == ad && !ov ##1 !ov;
	endsequence
	ovr_one_a: assert property (o1 |=> m1 == $past(e1))
		else $error("slave one override mode wrong");
	ovr_two_a: assert property (o2 |=> m2 == $past(e2))
		else $error("slave two override mode wrong");
	sel_one_a: assert property (s_wr(12'hd03, o1) |=>
		m1 == $past(cfg_wdata, 2)) else $error("slave one mode wrong");
	sel_two_a: assert property (s_wr(12'hd04, o2) |=>
		m2 == $past(cfg_wdata, 2)) else $error("slave two mode wrong");
	rb_one_a: assert property (cfg_rd && cfg_addr == 12'hd03 && !o1 |=>
		cfg_rdata_reg == m1) else $error("slave one readback wrong");
	rb_two_a: assert property (cfg_rd && cfg_addr == 12'hd04 && !o2 |=>
		cfg_rdata_reg == m2) else $error("slave two readback wrong");
	rd_idle_a: assert property (!cfg_rd |=> cfg_rdata_reg == 8'h00)
		else $error("read data not cleared");
	rd_unmap_a: assert property (cfg_rd && cfg_addr != 12'hd03 &&
		cfg_addr != 12'hd04 |=> cfg_rdata_reg == 8'h00)
		else $error("unmapped read not zero");
	// pin to pending is two sync stages plus the detector flop
	lvl_one_a: assert property ($past(reset_n) && $past(reset_n, 2) |=>
		((p1 ^ $past(r1, 3)) & $past(m1)) == 8'h00)
		else $error("slave one level request wrong");
	lvl_two_a: assert property ($past(reset_n) && $past(reset_n, 2) |=>
		((p2 ^ $past(r2, 3)) & $past(m2)) == 8'h00)
		else $error("slave two level request wrong");
	edge_one_a: assert property ($past(reset_n) && $past(reset_n, 2) &&
		$past(reset_n, 3) |=> (~p1 & $past(r1, 3) & ~$past(r1, 4) &
		~$past(m1)) == 8'h00) else $error("slave one edge missed");
	edge_two_a: assert property ($past(reset_n) && $past(reset_n, 2) &&
		$past(reset_n, 3) |=> (~p2 & $past(r2, 3) & ~$past(r2, 4) &
		~$past(m2)) == 8'h00) else $error("slave two edge missed");
endmodule
bind sptms_top sptms_checker u_chk (.*);

// >>> sptms_consts.vh
// constants for the slave trigger-mode select block
// assumes inclusion by bare name from the design files
//
// Notes on behaviour
// R1: slave one bit n: 0 edge, 1 level
// R2: slave two bit n: 0 edge, 1 level
// R3: slave one override set ignores channel register
// R4: slave one override uses init word level
// R5: slave one override clear uses channel bits
// R6: slave two override set ignores channel register
// R7: slave two override uses init word level
// R8: slave two override clear uses channel bits
// R9: edge latches rising input; level follows high
`ifndef SPTMS_CONSTS_VH
`define SPTMS_CONSTS_VH
`define SPTMS_ADDR_W        12
`define SPTMS_OFF_SLAVE_ONE 12'hd03
`define SPTMS_OFF_SLAVE_TWO 12'hd04
`define SPTMS_SEL_RESET     8'h00
`define SPTMS_MODE_EDGE     1'h0
`define SPTMS_MODE_LEVEL    1'h1
`endif

// >>> sptms_req_src.sv
// request pin source for both slave controllers
// assumes the bench sets the wanted pin levels
`timescale 1ns/100ps
module sptms_req_src (
	input  wire        clk_sys,
	input  wire [15:0] want,
	output reg  [15:0] req_out
);
	always @(posedge clk_sys) req_out <= want;
endmodule

// >>> sptms_tb_top.sv
// self-checking bench for sptms_top
// assumes the checker and the request source are compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
	miscompares++; \
	$display("MISMATCH %0t got %h want %h", $time, g, e); end end
module sptms_tb_top;
	reg         clk_sys = 0;
	reg         reset_n = 0;
	reg  [11:0] a = 0;
	reg         wr = 0;
	reg         rd = 0;
	reg  [7:0]  wd = 0;
	reg  [3:0]  g = 0;
	reg  [15:0] want = 0;
	reg  [15:0] ack = 0;
	wire [15:0] req, pend, mode;
	wire [7:0]  rdq;
	integer     miscompares = 0;
	integer     compares = 0;
	always #20 clk_sys = ~clk_sys;
	sptms_req_src u_src (.clk_sys(clk_sys), .want(want), .req_out(req));
	sptms_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_addr(a),
		.cfg_wr(wr), .cfg_rd(rd), .cfg_wdata(wd), .cfg_rdata_reg(rdq),
		.slave_one_global_override(g[0]), .slave_two_global_override(g[1]),
		.slave_one_global_level_select(g[2]),
		.slave_two_global_level_select(g[3]),
		.slave_one_req_in(req[7:0]), .slave_two_req_in(req[15:8]),
		.slave_one_req_ack(ack[7:0]), .slave_two_req_ack(ack[15:8]),
		.slave_one_req_pend(pend[7:0]), .slave_two_req_pend(pend[15:8]),
		.slave_one_mode_reg(mode[7:0]), .slave_two_mode_reg(mode[15:8]));
	task acc(input [11:0] ad, input [7:0] d, input w, input [7:0] e);
		@(negedge clk_sys) a = ad;
		wd = d;
		wr = w;
		@(negedge clk_sys) wr = 0;
		rd = 1;
		@(negedge clk_sys) rd = 0;
		`CHK(rdq, e)
	endtask
	task t_regs;
		acc(12'hd03, 8'h00, 0, 8'h00);
		acc(12'hd04, 8'h00, 0, 8'h00);
		acc(12'hd03, 8'ha5, 1, 8'ha5);
		acc(12'hd04, 8'h3c, 1, 8'h3c);
		acc(12'hd05, 8'hff, 1, 8'h00);
		`CHK(mode, 16'h3ca5)
		$display("regs done");
	endtask
	task t_ovr;
		g = 4'h7;
		@(negedge clk_sys);
		`CHK(mode, 16'h00ff)
		g = 4'hb;
		@(negedge clk_sys);
		`CHK(mode, 16'hff00)
		g = 0;
		@(negedge clk_sys);
		`CHK(mode, 16'h3ca5)
		$display("override done");
	endtask
	task t_det;
		want = 16'hffff;
		repeat (5) @(negedge clk_sys);
		`CHK(pend, 16'hffff)
		want = 0;
		repeat (5) @(negedge clk_sys);
		`CHK(pend, 16'hc35a)
		ack = 16'hffff;
		@(negedge clk_sys) ack = 0;
		@(negedge clk_sys);
		`CHK(pend, 16'h0000)
		$display("detect done");
	endtask
	task t_rst;
		@(negedge clk_sys) reset_n = 0;
		repeat (2) @(negedge clk_sys);
		`CHK(mode, 16'h0000)
		`CHK(pend, 16'h0000)
		reset_n = 1;
		acc(12'hd03, 8'h00, 0, 8'h00);
		acc(12'hd04, 8'h00, 0, 8'h00);
		`CHK(mode, 16'h0000)
		$display("reset done");
	endtask
	task end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk_sys);
		reset_n = 1;
		t_regs;
		t_ovr;
		t_det;
		t_rst;
		end_sim;
	end
	initial begin
		#(300 * 40);
		miscompares++;
		end_sim;
	end
endmodule

// >>> sptms_top.v
// trigger-mode selection for both slave interrupt controllers
// assumes a single-cycle config-space write/read port on clk_sys;
// request lines arrive from pins and are synchronised here
`timescale 1ns/100ps
`include "sptms_consts.vh"
module sptms_top (
	input  wire                     clk_sys,
	input  wire                     reset_n,
	input  wire [`SPTMS_ADDR_W-1:0] cfg_addr,
	input  wire                     cfg_wr,
	input  wire                     cfg_rd,
	input  wire [7:0]               cfg_wdata,
	output reg  [7:0]               cfg_rdata_reg,
	input  wire                     slave_one_global_override,
	input  wire                     slave_two_global_override,
	input  wire                     slave_one_global_level_select,
	input  wire                     slave_two_global_level_select,
	input  wire [7:0]               slave_one_req_in,
	input  wire [7:0]               slave_two_req_in,
	input  wire [7:0]               slave_one_req_ack,
	input  wire [7:0]               slave_two_req_ack,
	output wire [7:0]               slave_one_req_pend,
	output wire [7:0]               slave_two_req_pend,
	output reg  [7:0]               slave_one_mode_reg,
	output reg  [7:0]               slave_two_mode_reg
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg  [7:0] slave_one_channel_trigger_select_reg;
	reg  [7:0] slave_one_channel_trigger_select_next;
	reg  [7:0] slave_two_channel_trigger_select_reg;
	reg  [7:0] slave_two_channel_trigger_select_next;
	reg  [7:0] slave_one_mode_next;
	reg  [7:0] slave_two_mode_next;
	reg  [7:0] cfg_rdata_next;
	reg  [7:0] s1_sync1_reg;
	reg  [7:0] s1_sync2_reg;
	reg  [7:0] s2_sync1_reg;
	reg  [7:0] s2_sync2_reg;
	wire       slave_one_hit;
	wire       slave_two_hit;
	wire       slave_one_wr;
	wire       slave_two_wr;
	wire       slave_one_rd;
	wire       slave_two_rd;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// true when the offset selects the given register
	function sptms_addr_hit;
		input [`SPTMS_ADDR_W-1:0] addr;
		input [`SPTMS_ADDR_W-1:0] offset;
		begin
			sptms_addr_hit = (addr == offset);
		end
	endfunction

	// write data on a hit, otherwise hold the old value
	function [7:0] sptms_reg_update;
		input       hit;
		input [7:0] wdata;
		input [7:0] current;
		begin
			if (hit)
				sptms_reg_update = wdata;
			else
				sptms_reg_update = current;
		end
	endfunction

	// effective mode: override picks init-word level for all channels
	function [7:0] sptms_effective;
		input       override;
		input       level_sel;
		input [7:0] chan_sel;
		begin
			if (override)
				sptms_effective = {8{level_sel}};
			else
				sptms_effective = chan_sel;
		end
	endfunction

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign slave_one_hit = sptms_addr_hit(cfg_addr,
		`SPTMS_OFF_SLAVE_ONE);
	assign slave_two_hit = sptms_addr_hit(cfg_addr,
		`SPTMS_OFF_SLAVE_TWO);

	// strobes to any other offset match nothing and are dropped
	assign slave_one_wr  = cfg_wr & slave_one_hit;
	assign slave_two_wr  = cfg_wr & slave_two_hit;
	assign slave_one_rd  = cfg_rd & slave_one_hit;
	assign slave_two_rd  = cfg_rd & slave_two_hit;

	// ------------------------------------------------------------
	// per-channel select registers
	// ------------------------------------------------------------
	always @* begin
		slave_one_channel_trigger_select_next = sptms_reg_update(
			slave_one_wr, cfg_wdata,
			slave_one_channel_trigger_select_reg); // see R1
		slave_two_channel_trigger_select_next = sptms_reg_update(
			slave_two_wr, cfg_wdata,
			slave_two_channel_trigger_select_reg); // see R2
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			slave_one_channel_trigger_select_reg <= `SPTMS_SEL_RESET;
		end else begin
			slave_one_channel_trigger_select_reg <=
				slave_one_channel_trigger_select_next;
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			slave_two_channel_trigger_select_reg <= `SPTMS_SEL_RESET;
		end else begin
			slave_two_channel_trigger_select_reg <=
				slave_two_channel_trigger_select_next;
		end
	end

	// ------------------------------------------------------------
	// effective trigger mode
	// ------------------------------------------------------------
	// registered so a mode change reaches all eight detectors
	// on the same edge; costs one cycle of latency
	always @* begin
		slave_one_mode_next = sptms_effective(
			slave_one_global_override, // see R3 see R5
			slave_one_global_level_select, // see R4
			slave_one_channel_trigger_select_reg); // see R1
		slave_two_mode_next = sptms_effective(
			slave_two_global_override, // see R6 see R8
			slave_two_global_level_select, // see R7
			slave_two_channel_trigger_select_reg); // see R2
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			slave_one_mode_reg <= `SPTMS_SEL_RESET;
		end else begin
			slave_one_mode_reg <= slave_one_mode_next;
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			slave_two_mode_reg <= `SPTMS_SEL_RESET;
		end else begin
			slave_two_mode_reg <= slave_two_mode_next;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// reads return the written selects, not the effective mode
	always @* begin
		cfg_rdata_next = 8'h00;
		if (slave_one_rd)
			cfg_rdata_next = slave_one_channel_trigger_select_reg;
		else if (slave_two_rd)
			cfg_rdata_next = slave_two_channel_trigger_select_reg;
	end

	// idle and unmapped reads leave zero on the bus
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_rdata_reg <= 8'h00;
		end else begin
			cfg_rdata_reg <= cfg_rdata_next;
		end
	end

	// ------------------------------------------------------------
	// request synchronisers
	// ------------------------------------------------------------
	// two flops per pin; only the second stage feeds the detectors
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s1_sync1_reg <= 8'h00;
			s1_sync2_reg <= 8'h00;
		end else begin
			s1_sync1_reg <= slave_one_req_in;
			s1_sync2_reg <= s1_sync1_reg;
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s2_sync1_reg <= 8'h00;
			s2_sync2_reg <= 8'h00;
		end else begin
			s2_sync1_reg <= slave_two_req_in;
			s2_sync2_reg <= s2_sync1_reg;
		end
	end

	// ------------------------------------------------------------
	// detectors
	// ------------------------------------------------------------
	// reset clears the synchronisers and the edge history to low,
	// so a pin held high through reset is seen as a rising edge after it
	sptms_channel_detect u_slave_one (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.mode_sel     (slave_one_mode_reg),
		.req_in       (s1_sync2_reg),
		.req_ack      (slave_one_req_ack),
		.req_pend_reg (slave_one_req_pend)
	);

	sptms_channel_detect u_slave_two (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.mode_sel     (slave_two_mode_reg),
		.req_in       (s2_sync2_reg),
		.req_ack      (slave_two_req_ack),
		.req_pend_reg (slave_two_req_pend)
	);
endmodule
